// ===== pkg/sec_map.svh
/*
  Constants of the serial EEPROM command port: field widths, opcode and
  qualifier encodings, erase pattern and the programming time.
  Assumes it is included by its bare name from the modules.
*/
`ifndef SEC_MAP_SVH
`define SEC_MAP_SVH

`define SEC_OPC_W        2
`define SEC_ADDR_W       8
`define SEC_DATA_W       16
`define SEC_WORDS        256
`define SEC_SYNC_STAGES  2

`define SEC_OPC_READ     2'h2
`define SEC_OPC_WRITE    2'h1
`define SEC_OPC_ERASE    2'h3
`define SEC_OPC_EXT      2'h0

`define SEC_QUAL_WEN     2'h3
`define SEC_QUAL_WR_ALL  2'h1
`define SEC_QUAL_WR_DIS  2'h0
`define SEC_QUAL_ER_ALL  2'h2

`define SEC_ERASED_WORD  16'hffff
`define SEC_ADDR_LAST    5'h07
`define SEC_DATA_LAST    5'h0f
`define SEC_READ_LAST    5'h10

`define SEC_CLK_MHZ      200
`define SEC_TWP_US       15000
`define SEC_PROG_CYCLES  (`SEC_TWP_US * `SEC_CLK_MHZ)

`endif

// ===== pkg/sec_pkg.sv
/*
  Types of the serial EEPROM command port: command states and decoded
  instructions. Assumes sec_map.svh is on the include path.
*/
`default_nettype none
package sec_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,  // waiting for a start bit
    ST_OPC  = 3'h1,  // shifting the opcode
    ST_ADDR = 3'h2,  // shifting the address field
    ST_DATA = 3'h3,  // shifting the data field
    ST_READ = 3'h4,  // driving read data out
    ST_WAIT = 3'h5   // command complete, waiting for deselect
  } sec_state_t;

  typedef enum logic [2:0] {
    cmd_none          = 3'h0,
    cmd_read          = 3'h1,
    cmd_write_enable  = 3'h2,
    cmd_write         = 3'h3,
    write_all_cmd     = 3'h4,
    write_disable_cmd = 3'h5,
    cmd_erase         = 3'h6,
    erase_all_cmd     = 3'h7
  } sec_cmd_t;
endpackage
`default_nettype wire

// ===== pkg/sec_pin_if.sv
/*
  Synchronised serial pin levels passed from the input synchroniser to the
  command logic. Assumes both ends run on the same clock.
*/
`default_nettype none
interface sec_pin_if;
  logic select;
  logic sck;
  logic sdi;
  modport src (output select, output sck, output sdi);
  modport dst (input select, input sck, input sdi);
endinterface
`default_nettype wire

// ===== rtl/sec_sync.sv
/*
  Two-flop synchroniser for the select, serial clock and data-in pins.
  Assumes the pins are asynchronous to clk_in and slow against it.
*/
`default_nettype none
`include "sec_map.svh"
module sec_sync
  import sec_pkg::*;
(
  input  wire logic clk_in,           // core clock
  input  wire logic reset_n_in,       // async reset, active low
  input  wire logic select_in,        // raw select pin
  input  wire logic serial_clock_in,  // raw serial clock pin
  input  wire logic serial_data_in,   // raw serial data pin
  sec_pin_if.src    pins              // synchronised levels
);
  logic [`SEC_SYNC_STAGES*3-1:0] stage;
  logic [`SEC_SYNC_STAGES*3-1:0] next_stage;

  // shift raw pins in; only the last stage leaves this module
  always_comb begin
    next_stage = {stage[2:0], select_in, serial_clock_in, serial_data_in};
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage <= '0;
    end else begin
      stage <= next_stage;
    end
  end

  assign pins.select = stage[5];
  assign pins.sck    = stage[4];
  assign pins.sdi    = stage[3];
endmodule
`default_nettype wire

// ===== rtl/sec_top.sv
/*
  Command port of a 256 x 16 serial EEPROM: decodes the seven instructions,
  keeps the write-enable latch, runs the self-timed programming cycle and
  shows ready/busy on data out. Assumes the serial clock is far slower than
  clk_in so every edge is seen after synchronisation.
*/
`default_nettype none
`include "sec_map.svh"
module sec_top
  import sec_pkg::*;
#(
  parameter int PROG_CYCLES = `SEC_PROG_CYCLES  // programming time in clk_in cycles
) (
  input  wire logic clk_in,           // 200 MHz core clock
  input  wire logic reset_n_in,       // async reset, active low
  input  wire logic select_in,        // select pin, high selects
  input  wire logic serial_clock_in,  // serial clock from the master
  input  wire logic serial_data_in,   // serial data from the master
  output var  logic data_out,         // serial data / status level
  output var  logic data_oe_n_out     // low while data_out is driven
);
  localparam int CNT_W = $clog2(PROG_CYCLES + 1);

  // a zero-length programming cycle would never show busy; refuse it
  if (PROG_CYCLES < 1) begin : g_prog_check
    $error("PROG_CYCLES must be at least 1");
  end

  sec_pin_if pins ();

  sec_sync u_sync (
    .clk_in          (clk_in),
    .reset_n_in      (reset_n_in),
    .select_in       (select_in),
    .serial_clock_in (serial_clock_in),
    .serial_data_in  (serial_data_in),
    .pins            (pins)
  );

  sec_state_t               state;
  sec_state_t               next_state;
  sec_cmd_t                 cmd;
  sec_cmd_t                 next_cmd;
  logic                     sck_q;
  logic                     cs_q;
  logic [4:0]               bit_cnt;
  logic [4:0]               next_bit_cnt;
  logic [`SEC_OPC_W-1:0]    opc;
  logic [`SEC_OPC_W-1:0]    next_opc;
  logic [`SEC_ADDR_W-1:0]   addr;
  logic [`SEC_ADDR_W-1:0]   next_addr;
  logic [`SEC_DATA_W-1:0]   sreg;
  logic [`SEC_DATA_W-1:0]   next_sreg;
  logic                     wel;
  logic                     next_wel;
  logic                     busy;
  logic                     next_busy;
  logic [CNT_W-1:0]         prog_cnt;
  logic [CNT_W-1:0]         next_prog_cnt;
  logic                     show;
  logic                     next_show;
  logic                     next_data_out;
  logic                     next_data_oe_n;
  logic [`SEC_DATA_W-1:0]   mem      [`SEC_WORDS];
  logic [`SEC_DATA_W-1:0]   next_mem [`SEC_WORDS];

  logic                     sck_rise;
  logic                     cs_fall;
  logic                     commit;
  logic [`SEC_ADDR_W-1:0]   full_addr;

  // edges read only the second synchroniser stage and its delayed copy
  assign sck_rise  = pins.select & pins.sck & ~sck_q;
  assign cs_fall   = cs_q & ~pins.select;
  assign full_addr = {addr[`SEC_ADDR_W-2:0], pins.sdi};
  // only a fully shifted command acts on deselect, so partial ones vanish
  assign commit    = cs_fall & (state == ST_WAIT);

  // command shifting, decode, latch, programming and output levels
  always_comb begin
    next_state     = state;
    next_cmd       = cmd;
    next_bit_cnt   = bit_cnt;
    next_opc       = opc;
    next_addr      = addr;
    next_sreg      = sreg;
    next_wel       = wel;
    next_busy      = busy;
    next_prog_cnt  = prog_cnt;
    next_show      = show;
    next_data_out  = data_out;
    next_data_oe_n = data_oe_n_out;
    next_mem       = mem;

    // self-timed cycle; select activity does not touch it
    if (busy) begin
      if (prog_cnt == CNT_W'(1)) begin
        next_busy = 1'b0;
      end
      next_prog_cnt = prog_cnt - CNT_W'(1);
    end

    // a start bit after ready clears the status display
    if (show && !busy && sck_rise && pins.sdi) begin
      next_show = 1'b0;
    end

    case (state)
      ST_IDLE: begin
        // zeros before the start bit are skipped; nothing starts while busy
        if (sck_rise && pins.sdi && !busy) begin
          next_state   = ST_OPC;
          next_bit_cnt = 5'h00;
        end
      end
      ST_OPC: begin
        if (sck_rise) begin
          next_opc     = {opc[0], pins.sdi};
          next_bit_cnt = bit_cnt + 5'h01;
          if (bit_cnt == 5'h01) begin
            next_state   = ST_ADDR;
            next_bit_cnt = 5'h00;
          end
        end
      end
      ST_ADDR: begin
        if (sck_rise) begin
          next_addr    = full_addr;
          next_bit_cnt = bit_cnt + 5'h01;
          // decode only after all eight address bits have arrived
          if (bit_cnt == `SEC_ADDR_LAST) begin
            next_bit_cnt = 5'h00;
            next_state   = ST_WAIT;
            case (opc)
              `SEC_OPC_READ: begin
                // reads ignore the latch; dummy 0 goes out now
                next_cmd       = cmd_read;
                next_state     = ST_READ;
                next_sreg      = mem[full_addr];
                next_data_out  = 1'b0;
                next_data_oe_n = 1'b0;
              end
              `SEC_OPC_WRITE: begin
                next_cmd   = cmd_write;
                next_state = ST_DATA;
              end
              `SEC_OPC_ERASE: begin
                next_cmd = cmd_erase;
              end
              default: begin
                case (full_addr[`SEC_ADDR_W-1 -: 2])
                  `SEC_QUAL_WEN:   next_cmd = cmd_write_enable;
                  `SEC_QUAL_WR_ALL: begin
                    next_cmd   = write_all_cmd;
                    next_state = ST_DATA;
                  end
                  `SEC_QUAL_WR_DIS: next_cmd = write_disable_cmd;
                  default:         next_cmd = erase_all_cmd;
                endcase
              end
            endcase
          end
        end
      end
      ST_DATA: begin
        if (sck_rise) begin
          next_sreg    = {sreg[`SEC_DATA_W-2:0], pins.sdi};
          next_bit_cnt = bit_cnt + 5'h01;
          if (bit_cnt == `SEC_DATA_LAST) begin
            next_state = ST_WAIT;
          end
        end
      end
      ST_READ: begin
        // level moves only on a serial clock rise, MSB first
        if (sck_rise && bit_cnt != `SEC_READ_LAST) begin
          next_data_out = sreg[`SEC_DATA_W-1];
          next_sreg     = {sreg[`SEC_DATA_W-2:0], 1'b0};
          next_bit_cnt  = bit_cnt + 5'h01;
        end
      end
      ST_WAIT: begin
        // extra clocks past the last bit are ignored until deselect
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    // deselect: execute a finished command
    if (commit) begin
      case (cmd)
        cmd_write_enable:  next_wel = 1'b1;
        write_disable_cmd: next_wel = 1'b0;
        default: begin
        end
      endcase
      if (wel && !busy && cmd != cmd_read && cmd != cmd_write_enable &&
          cmd != write_disable_cmd && cmd != cmd_none) begin
        next_busy     = 1'b1;
        next_prog_cnt = CNT_W'(PROG_CYCLES);
        next_show     = 1'b1;
        for (int i = 0; i < `SEC_WORDS; i++) begin
          if (cmd == write_all_cmd) begin
            next_mem[i] = sreg;
          end else if (cmd == erase_all_cmd) begin
            next_mem[i] = `SEC_ERASED_WORD;
          end
        end
        if (cmd == cmd_write) begin
          next_mem[addr] = sreg;
        end else if (cmd == cmd_erase) begin
          next_mem[addr] = `SEC_ERASED_WORD;
        end
      end
    end

    // deselect always returns to idle and releases the pin
    if (!pins.select) begin
      next_state     = ST_IDLE;
      next_cmd       = cmd_none;
      next_bit_cnt   = 5'h00;
      next_data_oe_n = 1'b1;
    end else if (next_state != ST_READ && next_show) begin
      // status is a plain level; no serial clock needed
      next_data_out  = ~next_busy;
      next_data_oe_n = 1'b0;
    end else if (next_state != ST_READ) begin
      next_data_oe_n = 1'b1;
    end
  end

  // register every group; memory resets erased, latch resets cleared
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state         <= ST_IDLE;
      cmd           <= cmd_none;
      sck_q         <= 1'b0;
      cs_q          <= 1'b0;
      bit_cnt       <= 5'h00;
      opc           <= 2'h0;
      addr          <= 8'h00;
      sreg          <= 16'h0000;
      wel           <= 1'b0;
      busy          <= 1'b0;
      prog_cnt      <= '0;
      show          <= 1'b0;
      data_out      <= 1'b0;
      data_oe_n_out <= 1'b1;
      for (int i = 0; i < `SEC_WORDS; i++) begin
        mem[i] <= `SEC_ERASED_WORD;
      end
    end else begin
      state         <= next_state;
      cmd           <= next_cmd;
      sck_q         <= pins.sck;
      cs_q          <= pins.select;
      bit_cnt       <= next_bit_cnt;
      opc           <= next_opc;
      addr          <= next_addr;
      sreg          <= next_sreg;
      wel           <= next_wel;
      busy          <= next_busy;
      prog_cnt      <= next_prog_cnt;
      show          <= next_show;
      data_out      <= next_data_out;
      data_oe_n_out <= next_data_oe_n;
      mem           <= next_mem;
    end
  end

  // checks on the command port
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  AST_START_BIT: assert property (
    state == ST_IDLE && sck_rise && pins.sdi && !busy && pins.select
    |=> state == ST_OPC) else $error("start bit not taken");
  AST_DESEL_IDLE: assert property (
    !pins.select |=> state == ST_IDLE && data_oe_n_out) else $error("deselect not reset");
  AST_WEL_SET: assert property (
    commit && cmd == cmd_write_enable |=> wel) else $error("latch not set");
  AST_WEL_CLR: assert property (
    commit && cmd == write_disable_cmd |=> !wel [*2]) else $error("latch not cleared");
  AST_NO_PROG_LOCKED: assert property (
    !wel && !busy |=> !busy) else $error("programming while locked");
  AST_READ_DUMMY: assert property (
    state == ST_ADDR && bit_cnt == `SEC_ADDR_LAST && sck_rise && opc == `SEC_OPC_READ
    |=> state == ST_READ && !data_out && !data_oe_n_out) else $error("dummy bit missing");
  AST_READ_STABLE: assert property (
    state == ST_READ && !sck_rise && pins.select |=> $stable(data_out))
    else $error("read data moved without clock");
  AST_BUSY_LOW: assert property (
    show && busy && pins.select && state != ST_READ |=> data_out != busy && !data_oe_n_out)
    else $error("busy not shown");
  AST_ERASE_ONES: assert property (
    commit && cmd == cmd_erase && wel && !busy |=> busy && mem[$past(addr)] == 16'hffff)
    else $error("erase did not set ones");
  AST_BUSY_BLOCKS: assert property (
    busy && state == ST_IDLE |=> state == ST_IDLE) else $error("command taken while busy");

  COV_READ_DONE: cover property (state == ST_READ && bit_cnt == `SEC_READ_LAST);
  COV_PROG_START: cover property ($rose(busy));
  COV_READY_SHOWN: cover property (show && !busy && pins.select && !data_oe_n_out);
  COV_WEN: cover property (commit && cmd == cmd_write_enable);
endmodule
`default_nettype wire

// ===== verif/sec_far_master.sv
/*
  Behavioural serial master standing at the far side of the command port.
  Assumes the bench calls its tasks one at a time and reads cap after shift.
*/
`default_nettype none
module sec_far_master (
  input  wire logic clk_in,      // bench core clock, used to align frames
  input  wire logic data_in,     // data pin level from the port
  input  wire logic data_oe_n_in,// port output enable, low drives
  output var  logic select_out,  // select pin
  output var  logic sck_out,     // serial clock pin, 48 ns period in frames
  output var  logic sdi_out      // serial data pin
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DESEL_CLKS = 200;  // 1 us of deselect at the 5 ns bench clock
  logic        line;
  logic [16:0] cap;
  realtime     t_fall;              // time of the latest select fall
  // pull-down on the released line, so a floating pin never reads as ready
  assign line = data_oe_n_in ? 1'b0 : data_in;
  initial begin
    select_out = 1'b0;
    sck_out    = 1'b0;
    sdi_out    = 1'b0;
    cap        = '0;
    t_fall     = 0.0;
  end
  // select rises with the clock still, which stays low outside frames
  task automatic open_frame();
    @(negedge clk_in);
    select_out = 1'b1;
    #24;
  endtask
  // n bits msb first; data changes with sck low, sampled 4 ns before each rise
  task automatic shift(input logic [30:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      sdi_out = v[i];
      #20 cap = {cap[15:0], line};
      #4 sck_out = 1'b1;
      #24 sck_out = 1'b0;
    end
    #20 cap = {cap[15:0], line};
  endtask
  // select falls before any further rise, then stays low the minimum deselect time
  task automatic close_frame();
    @(negedge clk_in);
    select_out = 1'b0;
    sdi_out    = ~sdi_out;
    t_fall     = $realtime;
    repeat (DESEL_CLKS) @(negedge clk_in);
  endtask
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
/*
  Self-checking bench of the command port: power-up state, locked and
  enabled programming, status polling, abort, erase and write-all.
  Assumes the far master model and a shortened programming time.
*/
`default_nettype none
`define CHK(a, b, msg) begin checks++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected at %0t: %s", $time, msg); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PG = 600;  // short programming time, still longer than two deselects
  logic clk_in;
  logic reset_n_in;
  logic select;
  logic sck;
  logic sdi;
  logic data_o;
  logic data_oe_n;
  int   err_total = 0;
  int   checks    = 0;

  sec_top #(.PROG_CYCLES(PG)) uut (
    .clk_in          (clk_in),
    .reset_n_in      (reset_n_in),
    .select_in       (select),
    .serial_clock_in (sck),
    .serial_data_in  (sdi),
    .data_out        (data_o),
    .data_oe_n_out   (data_oe_n)
  );
  sec_far_master m (
    .clk_in       (clk_in),
    .data_in      (data_o),
    .data_oe_n_in (data_oe_n),
    .select_out   (select),
    .sck_out      (sck),
    .sdi_out      (sdi)
  );

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // read with two leading zeros; dummy bit and word come from the capture
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    m.open_frame();
    m.shift({4'h0, 3'b110, a, 16'h0000}, 29);
    `CHK(m.cap[16], 1'b0, "dummy bit")
    `CHK(m.cap[15:0], exp, "read word")
    m.close_frame();
  endtask

  // status poll; prog says whether a programming cycle was started
  task automatic poll(input logic prog);
    int      n;
    realtime t0;
    realtime dt;
    t0 = m.t_fall;  // select fall that ended the programming command
    m.open_frame();
    repeat (3) @(negedge clk_in);
    if (!prog) begin
      `CHK(data_oe_n, 1'b1, "status without programming")
    end else begin
      `CHK(data_oe_n, 1'b0, "status not driven")
      `CHK(data_o, 1'b0, "not busy")
      m.close_frame();
      `CHK(data_oe_n, 1'b1, "driven while deselected")
      m.open_frame();
      n = 0;
      while (data_o !== 1'b1 && n < PG) begin
        @(negedge clk_in);
        n++;
      end
      if (n == PG) begin
        err_total++;
        report_and_stop();
      end
      // busy lasts PG clocks from the select fall, plus a few clocks of sync delay
      dt = $realtime - t0;
      `CHK(dt > PG * 5.0 && dt < PG * 5.0 + 40.0, 1'b1, "ready time")
      m.shift(31'h1, 1);
      repeat (2) @(negedge clk_in);
      `CHK(data_oe_n, 1'b1, "status not cleared")
    end
    m.close_frame();
  endtask

  // opcode 00 family; q is the top address pair, low bits arbitrary
  task automatic ext(input logic [1:0] q, input logic [15:0] d, input int n);
    m.open_frame();
    m.shift({4'h0, 3'b100, q, 6'h2a, d} >> (27 - n), n);
    m.close_frame();
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
    m.open_frame();
    m.shift({4'h0, 3'b101, a, d} >> (27 - n), n);
    m.close_frame();
  endtask

  task automatic t_power();
    `CHK(data_oe_n, 1'b1, "driven after reset")
    rd(8'h00, 16'hffff);
    wr(8'h05, 16'h1234, 27);
    poll(1'b0);
    rd(8'h05, 16'hffff);
  endtask

  task automatic t_write();
    ext(2'b11, 16'h0, 11);
    wr(8'ha5, 16'hc35a, 27);
    poll(1'b1);
    rd(8'ha5, 16'hc35a);
    rd(8'ha4, 16'hffff);
  endtask

  // write cut short in mid data: no change, no programming
  task automatic t_abort();
    wr(8'ha5, 16'h0f0f, 20);
    poll(1'b0);
    rd(8'ha5, 16'hc35a);
  endtask

  task automatic t_erase();
    m.open_frame();
    m.shift({20'h0, 3'b111, 8'ha5}, 11);
    m.close_frame();
    poll(1'b1);
    rd(8'ha5, 16'hffff);
  endtask

  task automatic t_write_all_cmd();
    ext(2'b01, 16'h5a5a, 27);
    poll(1'b1);
    rd(8'h00, 16'h5a5a);
    rd(8'hff, 16'h5a5a);
    ext(2'b10, 16'h0, 11);
    poll(1'b1);
    rd(8'h80, 16'hffff);
    rd(8'h00, 16'hffff);
  endtask

  task automatic t_disable();
    ext(2'b00, 16'h0, 11);
    wr(8'h10, 16'h1234, 27);
    poll(1'b0);
    rd(8'h10, 16'hffff);
  endtask

  // watchdog: a hang is counted and closed like any other mismatch
  initial begin
    #300us;
    err_total++;
    report_and_stop();
  end

  initial begin
    reset_n_in = 1'b0;
    repeat (8) @(negedge clk_in);
    reset_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    t_power();
    t_write();
    t_abort();
    t_erase();
    t_write_all_cmd();
    t_disable();
    report_and_stop();
  end
endmodule
`default_nettype wire
